/* shared/i2c_seq_pkg.sv */
// constants, register map and state type for the two-wire master sequencer
// assumes a single clock domain and an 8-bit register port
// How it works
// - begin request with idle lines loads generator
// - expiry with lines high drives data low
// - second period ends, request clears, generator stops
// - low lines during begin raise collision, idle
// - buffer write during begin sets write clash
// - low command bits locked while begin pending
// - repeat begin pulls clock, then releases data
// - release clock, high period, data low, done
// - begin flag on pins, event after expiry
// - repeat begin ignored unless sequencer idle
// - repeat begin collision on data low, clock
// - buffer write during repeat begin sets clash
// - idle buffer write sets full, starts sending
// - eighth falling edge clears full, releases data
// - ninth falling edge samples peer acknowledge
// - after ninth clock, event, generator stops
// - buffer write while shifting sets sticky clash
// - receive request ignored unless idle
// - receive eight bits, load buffer, flag, idle
// - reading buffer clears buffer full flag
// - new byte while full sets overrun
// - generator counts to zero, then stops
// - released clock waits high before reload
package i2c_seq_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int RELOAD_W = 7;
    localparam int TICK_DIV = 2;
    localparam logic [3:0] BITS_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    localparam logic [ADDR_W-1:0] REG_BUFFER = 3'h0;
    localparam logic [ADDR_W-1:0] REG_COMMAND = 3'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h2;
    localparam logic [ADDR_W-1:0] REG_RELOAD = 3'h3;
    localparam logic [ADDR_W-1:0] REG_CONTROL = 3'h4;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 3'h5;

    localparam int CMD_BEGIN = 0;
    localparam int CMD_REPEAT = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_RECEIVE = 3;
    localparam int CMD_ACKSEQ = 4;
    localparam int CMD_ACKVAL = 5;
    localparam int CMD_PEERACK = 6;
    localparam int STS_FULL = 0;
    localparam int STS_BEGIN = 3;
    localparam int CTL_ENABLE = 0;
    localparam int FLG_EVENT = 0;
    localparam int FLG_COLL = 1;
    localparam int FLG_CLASH = 2;
    localparam int FLG_OVERRUN = 3;

    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [RELOAD_W-1:0] RESET_RELOAD = 7'h00;

    typedef enum logic [3:0] {
        S_IDLE, S_BEG_WAIT, S_BEG_HOLD, S_RS_PULL, S_RS_SDA_HI,
        S_RS_REL, S_RS_BOTH, S_RS_SDA_LO, S_XF_PULL, S_XF_LOW,
        S_XF_REL, S_XF_HIGH
    } state_type;
endpackage

/* rtl/i2c_master_sequencer.sv */
// two-wire master sequencer: begin, repeated begin, byte send and receive
// pins are open drain; sda_in/scl_in are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
module i2c_master_sequencer #(
    parameter int TICK_DIV = i2c_seq_pkg::TICK_DIV
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [i2c_seq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [i2c_seq_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [i2c_seq_pkg::DATA_W-1:0] reg_rdata,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe
);
    localparam int RW = i2c_seq_pkg::RELOAD_W;
    localparam int DW = i2c_seq_pkg::DATA_W;

    // pin synchronisers; only the second stage is read
    logic [1:0] sda_sync_q;
    logic [1:0] scl_sync_q;
    logic sda_s;
    logic scl_s;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sda_sync_q <= 2'h3;
            scl_sync_q <= 2'h3;
        end else begin
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_sync_q <= {scl_sync_q[0], scl_in};
        end
    end
    assign sda_s = sda_sync_q[1];
    assign scl_s = scl_sync_q[1];

    // rate tick divider
    logic [7:0] div_q;
    logic tick_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (div_q == 8'(TICK_DIV - 1)) begin
            div_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    // registers
    i2c_seq_pkg::state_type state_q, state_d;
    logic [DW-1:0] buffer_q, shift_q, rdata_q;
    logic [RW-1:0] reload_q, cnt_q;
    logic run_q;
    logic [3:0] bit_q;
    logic rx_mode_q;
    logic scl_low_q, sda_low_q, scl_low_d, sda_low_d;
    logic enable_q;
    logic begin_req_q, rs_req_q, rx_req_q;
    logic stop_req_q, ackseq_req_q, ack_value_q, peer_ack_q;
    logic full_q, begin_det_q;
    logic event_q, coll_q, clash_q, overrun_q;

    // bus decode
    logic buf_wr, buf_rd, cmd_wr, rld_wr, ctl_wr, flg_wr;
    assign buf_wr = reg_wr && reg_addr == i2c_seq_pkg::REG_BUFFER;
    assign buf_rd = reg_rd && reg_addr == i2c_seq_pkg::REG_BUFFER;
    assign cmd_wr = reg_wr && reg_addr == i2c_seq_pkg::REG_COMMAND;
    assign rld_wr = reg_wr && reg_addr == i2c_seq_pkg::REG_RELOAD;
    assign ctl_wr = reg_wr && reg_addr == i2c_seq_pkg::REG_CONTROL;
    assign flg_wr = reg_wr && reg_addr == i2c_seq_pkg::REG_FLAGS;

    // idle means enabled, no sequence and no request waiting
    logic idle_free, cmd_lock, tx_go, clash_set;
    logic take_begin, take_rs, take_rx;
    assign idle_free = state_q == i2c_seq_pkg::S_IDLE && !begin_req_q
        && !rs_req_q && !rx_req_q && enable_q;
    assign cmd_lock = begin_req_q || rs_req_q;
    assign tx_go = buf_wr && idle_free;
    // any buffer write while a sequence runs is lost
    assign clash_set = buf_wr && !idle_free
        && enable_q;
    assign take_begin = cmd_wr && idle_free
        && reg_wdata[i2c_seq_pkg::CMD_BEGIN];
    assign take_rs = cmd_wr && idle_free && !take_begin
        && reg_wdata[i2c_seq_pkg::CMD_REPEAT];
    assign take_rx = cmd_wr && idle_free && !take_begin && !take_rs
        && reg_wdata[i2c_seq_pkg::CMD_RECEIVE];

    // rate generator
    logic brg_load, brg_done, abort;
    assign brg_done = run_q && tick_q && cnt_q == '0;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= i2c_seq_pkg::RESET_RELOAD;
            run_q <= 1'b0;
        end else if (abort) begin
            run_q <= 1'b0;
        end else if (brg_load) begin
            cnt_q <= reload_q;
            run_q <= 1'b1;
        end else if (brg_done) begin
            run_q <= 1'b0;
        end else if (run_q && tick_q) begin
            cnt_q <= cnt_q - 7'h01;
        end
    end

    // sequencer
    logic coll, ev_set, beg_set, clr_begin, clr_rs, clr_rx;
    logic bit_shift, ack_take, rx_done, full_clr_tx;
    logic [DW-1:0] rx_shift;
    assign rx_shift = {shift_q[DW-2:0], sda_s};
    assign abort = coll || !enable_q;

    always_comb begin
        state_d = state_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        brg_load = 1'b0;
        coll = 1'b0;
        ev_set = 1'b0;
        beg_set = 1'b0;
        clr_begin = 1'b0;
        clr_rs = 1'b0;
        clr_rx = 1'b0;
        bit_shift = 1'b0;
        ack_take = 1'b0;
        rx_done = 1'b0;
        full_clr_tx = 1'b0;
        case (state_q)
            i2c_seq_pkg::S_IDLE: begin
                if (begin_req_q) begin
                    if (sda_s && scl_s) begin
                        brg_load = 1'b1;
                        state_d = i2c_seq_pkg::S_BEG_WAIT;
                    end else begin
                        coll = 1'b1;
                    end
                end else if (rs_req_q) begin
                    scl_low_d = 1'b1;
                    state_d = i2c_seq_pkg::S_RS_PULL;
                end else if (rx_req_q || tx_go) begin
                    scl_low_d = 1'b1;
                    state_d = i2c_seq_pkg::S_XF_PULL;
                end
            end
            i2c_seq_pkg::S_BEG_WAIT: begin
                if (!scl_s) begin
                    coll = 1'b1;
                end else if (brg_done) begin
                    if (sda_s) begin
                        sda_low_d = 1'b1;
                        beg_set = 1'b1;
                        brg_load = 1'b1;
                        state_d = i2c_seq_pkg::S_BEG_HOLD;
                    end else begin
                        coll = 1'b1;
                    end
                end
            end
            i2c_seq_pkg::S_BEG_HOLD: begin
                if (brg_done) begin
                    clr_begin = 1'b1;
                    ev_set = 1'b1;
                    state_d = i2c_seq_pkg::S_IDLE;
                end
            end
            i2c_seq_pkg::S_RS_PULL: begin
                if (!scl_s) begin
                    sda_low_d = 1'b0;
                    brg_load = 1'b1;
                    state_d = i2c_seq_pkg::S_RS_SDA_HI;
                end
            end
            i2c_seq_pkg::S_RS_SDA_HI: begin
                if (brg_done) begin
                    if (sda_s) begin
                        scl_low_d = 1'b0;
                        state_d = i2c_seq_pkg::S_RS_REL;
                    end else begin
                        coll = 1'b1;
                    end
                end
            end
            i2c_seq_pkg::S_RS_REL: begin
                if (scl_s) begin
                    if (!sda_s) begin
                        coll = 1'b1;
                    end else begin
                        brg_load = 1'b1;
                        state_d = i2c_seq_pkg::S_RS_BOTH;
                    end
                end
            end
            i2c_seq_pkg::S_RS_BOTH: begin
                if (!scl_s) begin
                    coll = 1'b1;
                end else if (brg_done) begin
                    sda_low_d = 1'b1;
                    brg_load = 1'b1;
                    state_d = i2c_seq_pkg::S_RS_SDA_LO;
                end
            end
            i2c_seq_pkg::S_RS_SDA_LO: begin
                if (!sda_s && scl_s) begin
                    beg_set = 1'b1;
                end
                if (brg_done) begin
                    clr_rs = 1'b1;
                    ev_set = 1'b1;
                    state_d = i2c_seq_pkg::S_IDLE;
                end
            end
            i2c_seq_pkg::S_XF_PULL: begin
                // data changes only once the clock is seen low
                if (!scl_s) begin
                    brg_load = 1'b1;
                    sda_low_d = !rx_mode_q && bit_q != i2c_seq_pkg::ACK_SLOT
                        && !shift_q[DW-1];
                    state_d = i2c_seq_pkg::S_XF_LOW;
                end
            end
            i2c_seq_pkg::S_XF_LOW: begin
                if (brg_done) begin
                    scl_low_d = 1'b0;
                    state_d = i2c_seq_pkg::S_XF_REL;
                end
            end
            i2c_seq_pkg::S_XF_REL: begin
                if (scl_s) begin
                    brg_load = 1'b1;
                    state_d = i2c_seq_pkg::S_XF_HIGH;
                end
            end
            i2c_seq_pkg::S_XF_HIGH: begin
                // lost arbitration: we let data float high, someone pulled it
                if (!rx_mode_q && bit_q != i2c_seq_pkg::ACK_SLOT
                    && !sda_low_q && !sda_s) begin
                    coll = 1'b1;
                end else if (brg_done) begin
                    scl_low_d = 1'b1;
                    if (rx_mode_q) begin
                        bit_shift = 1'b1;
                        if (bit_q == i2c_seq_pkg::BITS_LAST) begin
                            rx_done = 1'b1;
                            clr_rx = 1'b1;
                            ev_set = 1'b1;
                            state_d = i2c_seq_pkg::S_IDLE;
                        end else begin
                            state_d = i2c_seq_pkg::S_XF_PULL;
                        end
                    end else if (bit_q == i2c_seq_pkg::ACK_SLOT) begin
                        ack_take = 1'b1;
                        ev_set = 1'b1;
                        state_d = i2c_seq_pkg::S_IDLE;
                    end else begin
                        bit_shift = 1'b1;
                        full_clr_tx = bit_q
                            == i2c_seq_pkg::BITS_LAST;
                        state_d = i2c_seq_pkg::S_XF_PULL;
                    end
                end
            end
            default: begin
                state_d = i2c_seq_pkg::S_IDLE;
            end
        endcase
        if (abort) begin
            state_d = i2c_seq_pkg::S_IDLE;
            scl_low_d = 1'b0;
            sda_low_d = 1'b0;
            brg_load = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= i2c_seq_pkg::S_IDLE;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            state_q <= state_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
        end
    end

    // bit counter and shift register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bit_q <= 4'h0;
            rx_mode_q <= 1'b0;
            shift_q <= i2c_seq_pkg::RESET_BYTE;
            buffer_q <= i2c_seq_pkg::RESET_BYTE;
        end else begin
            if (tx_go) begin
                shift_q <= reg_wdata;
                buffer_q <= reg_wdata;
                bit_q <= 4'h0;
                rx_mode_q <= 1'b0;
            end else if (state_q == i2c_seq_pkg::S_IDLE && rx_req_q) begin
                bit_q <= 4'h0;
                rx_mode_q <= 1'b1;
            end else if (bit_shift) begin
                shift_q <= rx_mode_q ? rx_shift : {shift_q[DW-2:0], 1'b0};
                bit_q <= bit_q + 4'h1;
            end
            if (rx_done) begin
                buffer_q <= rx_shift;
            end
        end
    end

    // command and control registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            enable_q <= 1'b0;
            reload_q <= i2c_seq_pkg::RESET_RELOAD;
            begin_req_q <= 1'b0;
            rs_req_q <= 1'b0;
            rx_req_q <= 1'b0;
            stop_req_q <= 1'b0;
            ackseq_req_q <= 1'b0;
            ack_value_q <= 1'b0;
            peer_ack_q <= 1'b0;
        end else begin
            if (ctl_wr) begin
                enable_q <= reg_wdata[i2c_seq_pkg::CTL_ENABLE];
            end
            if (rld_wr) begin
                reload_q <= reg_wdata[RW-1:0];
            end
            if (cmd_wr) begin
                ack_value_q <= reg_wdata[i2c_seq_pkg::CMD_ACKVAL];
            end
            if (cmd_wr && !cmd_lock) begin
                stop_req_q <= reg_wdata[i2c_seq_pkg::CMD_STOP];
                ackseq_req_q <= reg_wdata[i2c_seq_pkg::CMD_ACKSEQ];
            end
            if (abort) begin
                begin_req_q <= 1'b0;
                rs_req_q <= 1'b0;
                rx_req_q <= 1'b0;
            end else begin
                begin_req_q <= take_begin || (begin_req_q && !clr_begin);
                rs_req_q <= take_rs || (rs_req_q && !clr_rs);
                rx_req_q <= take_rx || (rx_req_q && !clr_rx);
            end
            if (ack_take) begin
                peer_ack_q <= sda_s;
            end
        end
    end

    // status and sticky flags; a hardware set beats a software clear
    logic [DW-1:0] clr_mask;
    assign clr_mask = flg_wr ? reg_wdata : '0;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            full_q <= 1'b0;
            begin_det_q <= 1'b0;
            event_q <= 1'b0;
            coll_q <= 1'b0;
            clash_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            full_q <= tx_go || rx_done || (full_q && !full_clr_tx
                && !buf_rd && !coll && enable_q);
            begin_det_q <= beg_set || (begin_det_q && enable_q);
            event_q <= ev_set
                || (event_q && !clr_mask[i2c_seq_pkg::FLG_EVENT]);
            coll_q <= coll || (coll_q && !clr_mask[i2c_seq_pkg::FLG_COLL]);
            clash_q <= clash_set
                || (clash_q && !clr_mask[i2c_seq_pkg::FLG_CLASH]);
            overrun_q <= (rx_done && full_q && !buf_rd)
                || (overrun_q && !clr_mask[i2c_seq_pkg::FLG_OVERRUN]);
        end
    end

    // read mux
    logic [DW-1:0] cmd_view, sts_view, flg_view, rd_mux;
    always_comb begin
        cmd_view = '0;
        cmd_view[i2c_seq_pkg::CMD_BEGIN] = begin_req_q;
        cmd_view[i2c_seq_pkg::CMD_REPEAT] = rs_req_q;
        cmd_view[i2c_seq_pkg::CMD_STOP] = stop_req_q;
        cmd_view[i2c_seq_pkg::CMD_RECEIVE] = rx_req_q;
        cmd_view[i2c_seq_pkg::CMD_ACKSEQ] = ackseq_req_q;
        cmd_view[i2c_seq_pkg::CMD_ACKVAL] = ack_value_q;
        cmd_view[i2c_seq_pkg::CMD_PEERACK] = peer_ack_q;
        sts_view = '0;
        sts_view[i2c_seq_pkg::STS_FULL] = full_q;
        sts_view[i2c_seq_pkg::STS_BEGIN] = begin_det_q;
        flg_view = '0;
        flg_view[i2c_seq_pkg::FLG_EVENT] = event_q;
        flg_view[i2c_seq_pkg::FLG_COLL] = coll_q;
        flg_view[i2c_seq_pkg::FLG_CLASH] = clash_q;
        flg_view[i2c_seq_pkg::FLG_OVERRUN] = overrun_q;
        case (reg_addr)
            i2c_seq_pkg::REG_BUFFER: rd_mux = buffer_q;
            i2c_seq_pkg::REG_COMMAND: rd_mux = cmd_view;
            i2c_seq_pkg::REG_STATUS: rd_mux = sts_view;
            i2c_seq_pkg::REG_RELOAD: rd_mux = {1'b0, reload_q};
            i2c_seq_pkg::REG_CONTROL: rd_mux = {7'h00, enable_q};
            i2c_seq_pkg::REG_FLAGS: rd_mux = flg_view;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd ? rd_mux : '0;
        end
    end

    // open drain: the driven level is always low, enables come from flops
    assign reg_rdata = rdata_q;
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe = sda_low_q;
    assign scl_oe = scl_low_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_begin_drive;
        state_q == i2c_seq_pkg::S_BEG_WAIT && brg_done && scl_s && sda_s
        && enable_q;
    endsequence
    sequence s_begin_hold;
        sda_low_q && !scl_low_q && begin_det_q;
    endsequence

    a_begin_load: assert property (
        state_q == i2c_seq_pkg::S_IDLE && begin_req_q && sda_s && scl_s
        && enable_q |=> run_q && cnt_q == $past(reload_q))
        else $error("begin did not load rate generator");
    a_begin_drive: assert property (
        s_begin_drive |=> s_begin_hold)
        else $error("begin condition not driven");
    a_begin_end: assert property (
        state_q == i2c_seq_pkg::S_BEG_HOLD && brg_done && enable_q
        |=> !begin_req_q && !run_q && sda_low_q && event_q)
        else $error("begin end wrong");
    a_collision_idle: assert property (
        coll |=> coll_q && state_q == i2c_seq_pkg::S_IDLE
        && !scl_low_q && !sda_low_q && !begin_req_q && !rs_req_q)
        else $error("collision did not abort");
    a_clash_keep: assert property (
        buf_wr && (begin_req_q || rs_req_q || rx_req_q) && enable_q
        && !rx_done |=> clash_q && $stable(buffer_q))
        else $error("buffer write during sequence not refused");
    a_cmd_lock: assert property (
        cmd_wr && cmd_lock |=> $stable(stop_req_q) && $stable(ackseq_req_q))
        else $error("command bits changed while locked");
    a_repeat_pull: assert property (
        state_q == i2c_seq_pkg::S_RS_PULL && !scl_s && enable_q
        |=> run_q && !sda_low_q && scl_low_q)
        else $error("repeat begin pull wrong");
    a_rel_reload: assert property (
        state_q == i2c_seq_pkg::S_XF_REL && scl_s && enable_q
        |=> run_q && cnt_q == $past(reload_q))
        else $error("released clock not reloaded");
    a_tx_start: assert property (
        tx_go |=> full_q && scl_low_q
        && state_q == i2c_seq_pkg::S_XF_PULL)
        else $error("transmit did not start");
    a_ack_end: assert property (
        ack_take && enable_q |=> event_q && !run_q && scl_low_q
        && !sda_low_q && peer_ack_q == $past(sda_s))
        else $error("ninth clock end wrong");
    a_rx_done: assert property (
        rx_done && enable_q |=> full_q && !rx_req_q && event_q
        && buffer_q == $past(rx_shift) && scl_low_q)
        else $error("receive end wrong");
    a_read_clear: assert property (
        buf_rd && !rx_done && !tx_go |=> !full_q)
        else $error("buffer read did not clear full");
    a_overrun: assert property (
        rx_done && full_q && !buf_rd |=> overrun_q)
        else $error("overrun not flagged");
    a_disable_idle: assert property (
        !enable_q |=> state_q == i2c_seq_pkg::S_IDLE
        && !begin_req_q && !rx_req_q && !scl_low_q && !sda_low_q)
        else $error("disable did not idle");
endmodule
`default_nettype wire

/* dv/i2c_slave_model.sv */
// slave on the two-wire bus: acks sent bytes, sends a byte on receive
// assumes the bench builds the open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
    input wire logic sda,
    input wire logic scl,
    input wire logic clr,
    input wire logic ack_on,
    input wire logic rx,
    input wire logic [7:0] tx_byte,
    output logic pull,
    output logic [7:0] seen
);
    int r = 0;
    int idx;
    // bit index moves only while clock is low, so data never changes high
    assign idx = scl ? r - 1 : r;
    assign pull = rx ? (idx >= 0 && idx < 8 && !tx_byte[7 - idx])
                     : (ack_on && idx == 8);
    always @(posedge scl or posedge clr) begin
        if (clr) begin
            r <= 0;
        end else begin
            r <= r + 1;
            if (r < 8) seen <= {seen[6:0], sda};
        end
    end
endmodule
`default_nettype wire

/* dv/i2c_master_sequencer_tb.sv */
// bench for the two-wire master sequencer over its register port
// assumes pull-ups on both lines; wire levels built from the enables
`timescale 1ns/1ps
`default_nettype none
module i2c_master_sequencer_tb;
    logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic clr = 1, ack_on = 1, rx = 0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, rdat, seen, tx_byte = 8'h00, reg_rdata;
    logic sda_oe, scl_oe, pull, sda, scl, sda_drv, scl_drv;
    int bad_count = 0, checked = 0;
    typedef struct {logic [7:0] d; logic a; logic [7:0] c;} row_type;
    row_type rows [3] = '{'{8'hA5, 1, 8'h00}, '{8'h5A, 0, 8'h40},
                          '{8'h01, 1, 8'h00}};
    assign sda = ~(sda_oe | pull);
    assign scl = ~scl_oe;
    i2c_master_sequencer #(.TICK_DIV(1)) dut_u (.clk_sys(clk_sys),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sda_in(sda), .sda_out(sda_drv), .sda_oe(sda_oe), .scl_in(scl),
        .scl_out(scl_drv), .scl_oe(scl_oe));
    i2c_slave_model s_u (.sda(sda), .scl(scl), .clr(clr), .ack_on(ack_on),
        .rx(rx), .tx_byte(tx_byte), .pull(pull), .seen(seen));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task automatic rdc(string n, logic [2:0] a, logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 rdat = reg_rdata;
        if (n != "") chk(n, e, rdat);
    endtask
    // polls the flags register, bounded at 400 reads so a hang ends the poll and the run goes on
    task automatic wait_flag(int b);
        rdat = 8'h00;
        for (int i = 0; i < 400 && rdat[b] !== 1'b1; i++) rdc("", 3'h5, 0);
    endtask
    task automatic rcv();
        wr(3'h5, 8'h01);
        clr = 1;
        #1 clr = 0;
        wr(3'h1, 8'h08);
        wait_flag(0);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1;
        clr = 0;
        for (int i = 0; i < 7; i++) rdc("reset", i[2:0], 8'h00);
        wr(3'h4, 8'h01);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h01);
        wr(3'h0, 8'hFF);
        wr(3'h1, 8'h09);
        wait_flag(0);
        rdc("cmd", 3'h1, 8'h00);
        rdc("status", 3'h2, 8'h08);
        rdc("flags", 3'h5, 8'h05);
        chk("lines", 8'h02, {6'h0, sda_oe, scl_oe});
        chk("drive", 8'h00, {6'h0, sda_drv, scl_drv});
        foreach (rows[k]) begin
            wr(3'h5, 8'h0F);
            clr = 1;
            #1 clr = 0;
            ack_on = rows[k].a;
            wr(3'h0, rows[k].d);
            rdc("full", 3'h2, 8'h09);
            wr(3'h0, 8'h77);
            wr(3'h1, 8'h0A);
            wait_flag(0);
            chk("wire", rows[k].d, seen);
            rdc("ack", 3'h1, rows[k].c);
            rdc("empty", 3'h2, 8'h08);
            rdc("clash", 3'h5, 8'h05);
            chk("held", 8'h01, {6'h0, sda_oe, scl_oe});
        end
        // disable first so the begin-detected bit is earned by the repeat
        wr(3'h4, 8'h00);
        wr(3'h4, 8'h01);
        wr(3'h5, 8'h0F);
        wr(3'h1, 8'h02);
        wait_flag(0);
        rdc("rsbeg", 3'h2, 8'h08);
        rdc("rsend", 3'h1, 8'h00);
        chk("rsline", 8'h02, {6'h0, sda_oe, scl_oe});
        wr(3'h5, 8'h0F);
        rx = 1;
        tx_byte = 8'hC3;
        rcv();
        rdc("rcv", 3'h1, 8'h00);
        rdc("rfull", 3'h2, 8'h09);
        rdc("rbyte", 3'h0, 8'hC3);
        rdc("read", 3'h2, 8'h08);
        wr(3'h1, 8'h10);
        rdc("akreq", 3'h1, 8'h10);
        rcv();
        rcv();
        rdc("over", 3'h5, 8'h09);
        wr(3'h5, 8'h0F);
        wr(3'h1, 8'h01);
        wait_flag(1);
        rdc("coll", 3'h5, 8'h02);
        rdc("abort", 3'h1, 8'h00);
        chk("free", 8'h00, {6'h0, sda_oe, scl_oe});
        wr(3'h4, 8'h00);
        rdc("off", 3'h2, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
